//--- verilog/lpm_map.vh
// constants for the low-power mode controller
`ifndef LPM_MAP_VH
`define LPM_MAP_VH
`define LPM_WAKE_DELAY 16'd4064
`define LPM_CNT_W 16
`define LPM_ST_RUN 2'h0
`define LPM_ST_STOP 2'h1
`define LPM_ST_WAIT 2'h2
`define LPM_ST_START 2'h3
`endif

//--- verilog/lpm_sync3.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module lpm_sync3 #(
   parameter RST_VAL = 1'b1
) (
   input wire sys_clk, // clock
   input wire rst, // synchronous reset
   input wire din, // asynchronous pin
   output reg dout // filtered level
);
   reg s1_r;
   reg s2_r;
   reg s3_r;
   // three stage flops and an output flop; output changes once stages two and three agree
   always @(posedge sys_clk) begin
      if (rst) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            dout <= s3_r;
         end
      end
   end
endmodule
`default_nettype wire

//--- verilog/lpm_ctrl.v
// low-power stop and wait mode controller
// Operation
// [RULE_01] stop mode gates the oscillator, halting timers and watchdog
// [RULE_02] stop entry clears the interrupt mask bit
// [RULE_03] stop mode holds all other state unchanged
// [RULE_04] stop exits only on external, keyboard, enabled supply-drop interrupt, or reset
// [RULE_05] stop-disable option makes stop a no-operation
// [RULE_06] after stop wake, wait 4064 cycles before execution resumes
// [RULE_07] wait suspends processor; core timer, 16-bit timer and converter run
// [RULE_08] wait exits on external, keyboard, supply-drop, or enabled timer interrupts
// [RULE_09] wait entry clears interrupt mask, other state held
// [RULE_10] enabled core timer interrupts give periodic wait wake-up
// [RULE_11] low supply-drop input starts a routine or hardware interrupt
// [RULE_12] low reset input forces a known start-up state
// [RULE_13] cycle counts are bus cycles, oscillator divided by two
// [RULE_14] programmable-memory variant always enables stop
// [RULE_15] wake delay counts from oscillator restart; processor stalled meanwhile
`timescale 1ns/1ps
`default_nettype none
`include "lpm_map.vh"
module lpm_ctrl #(
   parameter WAKE_DELAY = `LPM_WAKE_DELAY, // bus cycles after stop wake
   parameter PROG_VARIANT = 1'b0 // programmable-memory variant
) (
   input wire sys_clk, // bus clock
   input wire rst, // synchronous reset, active high
   input wire reset_pin_n, // external reset pin, active low
   input wire supply_drop_input_n, // supply-drop pin, active low
   input wire ext_irq_pin_n, // external interrupt pin, active low
   input wire stop_req, // core executes stop, one-cycle pulse
   input wire wait_req, // core executes wait, one-cycle pulse
   input wire stop_disable_opt, // factory option: stop is no-operation
   input wire kbd_irq, // keyboard interrupt request
   input wire kbd_en, // keyboard interrupt enabled
   input wire sd_irq_en, // supply-drop interrupt enabled
   input wire sd_hw_mode, // 1: hardware interrupt, 0: software routine
   input wire ctimer_irq, // core timer interrupt request (enabled)
   input wire tmr16_irq, // 16-bit timer interrupt request (enabled)
   output reg osc_en, // oscillator enable
   output reg cpu_stall, // processor held
   output reg periph_clk_en, // timers and converter clock enable
   output reg state_hold, // registers and pins frozen
   output reg imask_clear, // clear interrupt mask bit pulse
   output reg stop_noop, // stop executed as no-operation pulse
   output reg sd_hw_irq, // supply-drop hardware interrupt
   output reg sd_sw_trap, // supply-drop software routine start pulse
   output reg core_reset, // internal reset to known state
   output reg wake_pulse, // wake event pulse
   output reg [1:0] mode // current mode
);
   ////////////////////////////////////////////////////////////////
   wire rst_pin_f;
   wire sd_f;
   wire irq_f;
   reg sd_prev_r;
   reg [1:0] st_r;
   reg [1:0] st_nxt;
   reg [`LPM_CNT_W-1:0] cnt_r;
   reg [`LPM_CNT_W-1:0] cnt_nxt;
   wire sync_rst;
   wire sd_fall;
   wire stop_wake;
   wire wait_wake;
   wire stop_ok;

   // one when the given state is a low-power mode
   function f_asleep;
      input [1:0] st;
      begin
         f_asleep = (st == `LPM_ST_STOP) || (st == `LPM_ST_WAIT);
      end
   endfunction

   // pin synchronisers
   // all three idle high, so leaving rst gives no false pin event
   lpm_sync3 #(.RST_VAL(1'b1)) u_rst_sync (
      .sys_clk(sys_clk), // bus clock
      .rst(rst), // block reset only, so the pin can release
      .din(reset_pin_n), // raw reset pin
      .dout(rst_pin_f) // filtered reset pin
   );
   lpm_sync3 #(.RST_VAL(1'b1)) u_sd_sync (
      .sys_clk(sys_clk), // bus clock
      .rst(rst), // block reset
      .din(supply_drop_input_n), // raw supply-drop pin
      .dout(sd_f) // filtered supply-drop level
   );
   lpm_sync3 #(.RST_VAL(1'b1)) u_irq_sync (
      .sys_clk(sys_clk), // bus clock
      .rst(rst), // block reset
      .din(ext_irq_pin_n), // raw interrupt pin
      .dout(irq_f) // filtered interrupt level
   );

   ////////////////////////////////////////////////////////////////
   // wake qualifiers
   assign sync_rst = rst | ~rst_pin_f; // RULE_12
   assign sd_fall = sd_prev_r & ~sd_f; // RULE_11
   assign stop_wake = ~irq_f | (kbd_irq & kbd_en) | (~sd_f & sd_irq_en); // RULE_04
   assign wait_wake = ~irq_f | (kbd_irq & kbd_en) | ~sd_f | ctimer_irq | tmr16_irq; // RULE_08 RULE_10
   assign stop_ok = PROG_VARIANT | ~stop_disable_opt; // RULE_05 RULE_14

   // next-state logic
   always @* begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      case (st_r)
         `LPM_ST_RUN: begin
            if (stop_req && stop_ok) begin
               st_nxt = `LPM_ST_STOP; // RULE_01
            end else if (wait_req && !stop_req) begin
               st_nxt = `LPM_ST_WAIT; // RULE_07
            end
         end
         `LPM_ST_STOP: begin
            if (stop_wake) begin
               st_nxt = `LPM_ST_START; // RULE_15
               cnt_nxt = WAKE_DELAY[`LPM_CNT_W-1:0] - 16'h0001;
            end
         end
         `LPM_ST_WAIT: begin
            if (wait_wake) begin
               st_nxt = `LPM_ST_RUN; // RULE_08
            end
         end
         `LPM_ST_START: begin
            if (cnt_r == 16'h0000) begin
               st_nxt = `LPM_ST_RUN; // RULE_06 RULE_13
            end else begin
               cnt_nxt = cnt_r - 16'h0001;
            end
         end
         default: begin
            st_nxt = `LPM_ST_RUN;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // state register and start-up delay counter
   always @(posedge sys_clk) begin
      if (sync_rst) begin
         st_r <= `LPM_ST_RUN; // RULE_12
         cnt_r <= 16'h0000;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // internal reset; drops one cycle after the last reset cycle
   always @(posedge sys_clk) begin
      if (sync_rst) begin
         core_reset <= 1'b1; // RULE_12
      end else begin
         core_reset <= 1'b0;
      end
   end

   // mode follows the next state, aligned with the gating outputs
   always @(posedge sys_clk) begin
      if (sync_rst) begin
         mode <= `LPM_ST_RUN;
      end else begin
         mode <= st_nxt;
      end
   end

   // clock gating; only stop halts oscillator and peripherals
   always @(posedge sys_clk) begin
      if (sync_rst) begin
         osc_en <= 1'b1;
         periph_clk_en <= 1'b1;
      end else begin
         osc_en <= (st_nxt != `LPM_ST_STOP); // RULE_01
         periph_clk_en <= (st_nxt != `LPM_ST_STOP); // RULE_01 RULE_07
      end
   end

   // processor stall covers stop, wait and the start-up delay
   always @(posedge sys_clk) begin
      if (sync_rst) begin
         cpu_stall <= 1'b0;
         state_hold <= 1'b0;
      end else begin
         cpu_stall <= (st_nxt != `LPM_ST_RUN); // RULE_07 RULE_15
         state_hold <= f_asleep(st_nxt); // RULE_03 RULE_09
      end
   end

   // one-cycle event pulses on mode entry and exit, and on a stop executed as no-operation
   always @(posedge sys_clk) begin
      if (sync_rst) begin
         imask_clear <= 1'b0;
         stop_noop <= 1'b0;
         wake_pulse <= 1'b0;
      end else begin
         imask_clear <= (st_r == `LPM_ST_RUN) && f_asleep(st_nxt); // RULE_02 RULE_09
         stop_noop <= (st_r == `LPM_ST_RUN) && stop_req && !stop_ok; // RULE_05
         wake_pulse <= (st_r != st_nxt) && f_asleep(st_r); // RULE_04 RULE_08
      end
   end

   // supply-drop indication; edge register idles high like the pin
   always @(posedge sys_clk) begin
      if (sync_rst) begin
         sd_prev_r <= 1'b1;
         sd_hw_irq <= 1'b0;
         sd_sw_trap <= 1'b0;
      end else begin
         sd_prev_r <= sd_f;
         sd_hw_irq <= ~sd_f & sd_hw_mode; // RULE_11
         sd_sw_trap <= sd_fall & ~sd_hw_mode; // RULE_11
      end
   end
endmodule
`default_nettype wire

//--- tb/lpm_core_model.sv
// processor core model issuing stop and wait pulses
`timescale 1ns/1ps
`default_nettype none
module lpm_core_model (
   input wire logic sys_clk, // clock
   input wire logic [1:0] op, // 1 stop, 2 wait
   output logic stop_req, // stop pulse
   output logic wait_req // wait pulse
);
   // one-cycle instruction pulses launched just after the edge
   always @(posedge sys_clk) begin
      stop_req <= op == 2'h1;
      wait_req <= op == 2'h2;
   end
endmodule
`default_nettype wire

//--- tb/lpm_ctrl_checker.sv
// assertion checker for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_checker #(parameter WAKE_DELAY = 8) (
   input wire logic sys_clk, rst, supply_drop_input_n, stop_req, wait_req, // clock and requests
   input wire logic stop_disable_opt, ctimer_irq, sd_hw_mode, osc_en, cpu_stall, // option, status
   input wire logic periph_clk_en, state_hold, imask_clear, stop_noop, sd_hw_irq, wake_pulse, // events
   input wire logic [1:0] mode // current mode
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   int cnt_r;
   // counts cycles spent in the start-up delay
   always @(posedge sys_clk) cnt_r <= (rst || mode != 2'h3) ? 0 : cnt_r + 1;
   sequence s_wake_exit;
      mode == 2'h3 ##1 mode == 2'h0;
   endsequence
   a_stop_gates: assert property (mode == 2'h1 |-> !osc_en && !periph_clk_en && state_hold)
      else $error("stop gating");
   a_stop_entry: assert property (mode == 2'h0 && stop_req && !stop_disable_opt |=> mode == 2'h1 && imask_clear)
      else $error("stop entry");
   a_stop_noop: assert property (mode == 2'h0 && stop_req && stop_disable_opt |=> stop_noop && mode == 2'h0)
      else $error("stop noop");
   a_wake_delay: assert property (s_wake_exit |-> cnt_r == WAKE_DELAY && !cpu_stall)
      else $error("wake delay");
   a_wait_run: assert property (mode == 2'h2 |-> periph_clk_en && cpu_stall && state_hold)
      else $error("wait run");
   a_wait_entry: assert property (mode == 2'h0 && wait_req && !stop_req |=> mode == 2'h2 && imask_clear)
      else $error("wait entry");
   a_timer_wake: assert property (mode == 2'h2 && ctimer_irq |-> ##[1:6] wake_pulse)
      else $error("timer wake");
   a_drop_irq: assert property ((!supply_drop_input_n && sd_hw_mode)[*7] |-> sd_hw_irq)
      else $error("drop irq");
endmodule
bind lpm_ctrl lpm_ctrl_checker #(.WAKE_DELAY(WAKE_DELAY)) chk_i (.sys_clk, .rst, .supply_drop_input_n,
   .stop_req, .wait_req, .stop_disable_opt, .ctimer_irq, .sd_hw_mode, .osc_en, .cpu_stall, .periph_clk_en,
   .state_hold, .imask_clear, .stop_noop, .sd_hw_irq, .wake_pulse, .mode);
`default_nettype wire

//--- tb/lpm_ctrl_tb.sv
// testbench for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_tb;
   logic sys_clk = 0, rst = 1, rp_n = 1, sd_n = 1, ext_n = 1, dis = 0, ct = 0, hw = 0;
   logic kb = 0, kbe = 0, sde = 0, t16 = 0;
   logic [1:0] op = 2'h0;
   wire stop_req, wait_req, osc_en, cpu_stall, pce, hold, imc, noop, sdh, crst, wk, sw;
   wire [1:0] mode;
   int failures = 0, n_checks = 0, k;
   always #50 sys_clk = ~sys_clk;
   lpm_core_model core (.sys_clk, .op, .stop_req, .wait_req);
   lpm_ctrl #(.WAKE_DELAY(8)) dut (.sys_clk, .rst, .reset_pin_n(rp_n), .supply_drop_input_n(sd_n),
      .ext_irq_pin_n(ext_n), .stop_req, .wait_req, .stop_disable_opt(dis), .kbd_irq(kb), .kbd_en(kbe),
      .sd_irq_en(sde), .sd_hw_mode(hw), .ctimer_irq(ct), .tmr16_irq(t16), .osc_en, .cpu_stall,
      .periph_clk_en(pce), .state_hold(hold), .imask_clear(imc), .stop_noop(noop), .sd_hw_irq(sdh),
      .sd_sw_trap(sw), .core_reset(crst), .wake_pulse(wk), .mode);
   // compares a seen value with the expected one
   task chk(input logic [15:0] s, input logic [15:0] e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %0t seen %h want %h", $time, s, e);
      end
   endtask
   task conclude;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // issues one instruction through the core model
   task exec(input logic [1:0] v);
      op = v;
      @(negedge sys_clk) op = 2'h0;
      @(negedge sys_clk);
   endtask
   // waits a bounded time for the wake pulse
   task wake;
      for (k = 0; k < 40 && wk !== 1'b1; k++) @(negedge sys_clk);
      if (k == 40) begin
         failures++;
         conclude;
      end
   endtask
   // waits a bounded time for the return to run mode
   task to_run;
      for (k = 0; k < 40 && mode !== 2'h0; k++) @(negedge sys_clk);
      if (k == 40) begin
         failures++;
         conclude;
      end
   endtask
   initial begin
      repeat (8) @(negedge sys_clk);
      rst = 0;
      @(negedge sys_clk);
      chk({osc_en, pce, crst, mode}, 16'h0018);
      repeat (4) @(negedge sys_clk);
      dis = 1;
      exec(2'h1);
      chk({noop, mode}, 16'h0004);
      dis = 0;
      exec(2'h1);
      chk({osc_en, pce, hold, imc, mode}, 16'h000D);
      ct = 1;
      repeat (6) @(negedge sys_clk);
      chk({osc_en, mode}, 16'h0001);
      ct = 0;
      ext_n = 0;
      wake;
      ext_n = 1;
      for (k = 0; k < 100 && mode === 2'h3 && cpu_stall === 1'b1; k++) @(negedge sys_clk);
      chk(k[15:0], 16'h0008);
      chk({cpu_stall, mode}, 16'h0000);
      exec(2'h2);
      chk({pce, imc, hold, mode}, 16'h001E);
      ct = 1;
      wake;
      chk({cpu_stall, mode}, 16'h0000);
      ct = 0;
      kb = 1;
      exec(2'h1);
      repeat (4) @(negedge sys_clk);
      chk({14'h0000, mode}, 16'h0001);
      kbe = 1;
      wake;
      kb = 0;
      kbe = 0;
      to_run;
      chk({cpu_stall, mode}, 16'h0000);
      exec(2'h1);
      sd_n = 0;
      for (k = 0; k < 10 && sw !== 1'b1; k++) @(negedge sys_clk);
      chk({15'h0000, sw}, 16'h0001);
      repeat (2) @(negedge sys_clk);
      chk({sw, mode}, 16'h0001);
      sde = 1;
      wake;
      sd_n = 1;
      sde = 0;
      to_run;
      exec(2'h2);
      t16 = 1;
      wake;
      chk({cpu_stall, mode}, 16'h0000);
      t16 = 0;
      hw = 1;
      sd_n = 0;
      repeat (8) @(negedge sys_clk);
      chk({15'h0000, sdh}, 16'h0001);
      sd_n = 1;
      rp_n = 0;
      repeat (8) @(negedge sys_clk);
      chk({crst, mode}, 16'h0004);
      rp_n = 1;
      repeat (6) @(negedge sys_clk);
      chk({crst, cpu_stall, mode}, 16'h0000);
      exec(2'h2);
      chk({imc, mode}, 16'h0006);
      conclude;
   end
endmodule
`default_nettype wire
